// ---- inc/spi_pkg.sv ----
// Shared constants and types of the synchronous serial port.
// Assumes a single 125 MHz clock and an 8-bit register port.
package spi_pkg;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 4;

  // Register offsets on the plain register port.
  localparam logic [2:0] OFF_IRQ_EN    = 3'h0;
  localparam logic [2:0] OFF_IRQ_FLAGS = 3'h1;
  localparam logic [2:0] OFF_IRQ_PRIO  = 3'h2;
  localparam logic [2:0] OFF_BUF       = 3'h3;
  localparam logic [2:0] OFF_CON1      = 3'h4;
  localparam logic [2:0] OFF_STAT      = 3'h5;
  localparam logic [2:0] OFF_CTL       = 3'h6;

  // Field positions.
  localparam int unsigned IRQ_BIT     = 3;
  localparam int unsigned CON_WRITE_COLLISION_FLAG    = 7;
  localparam int unsigned CON_OV      = 6;
  localparam int unsigned CON_EN      = 5;
  localparam int unsigned CON_CKP     = 4;
  localparam int unsigned STAT_SMP    = 7;
  localparam int unsigned STAT_CKE    = 6;
  localparam int unsigned STAT_BF     = 0;
  localparam int unsigned CTL_PRIO    = 7;
  localparam int unsigned CTL_GROUP   = 6;
  localparam int unsigned CTL_SDO_OFF = 0;

  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hFF;

  // Port mode select encodings.
  localparam logic [3:0] MODE_DIV4  = 4'h0;
  localparam logic [3:0] MODE_DIV16 = 4'h1;
  localparam logic [3:0] MODE_DIV64 = 4'h2;
  localparam logic [3:0] MODE_TMR2  = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV   = 4'h5;

  // Half bit periods in system clocks for the divided master rates.
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [3:0] LAST_EDGE  = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_SHIFT = 3'b100
  } xfer_state_t;

  typedef struct packed {
    logic       sample_phase_bit;
    logic       cke;
    logic       clock_polarity_bit;
    logic [3:0] mode;
  } link_cfg_t;

endpackage

// ---- rtl/spi_port.sv ----
// Synchronous serial port, master or slave, with its register file.
// Assumes all pin inputs are synchronous to clk and a one-clock
// register port whose read data stand in the cycle after the strobe.
// Function
// - Master drives serial clock; a start from idle waits until the receive FIFO has room.
// - Master write to transfer buffer launches one byte send and receive.
// - With data output disabled, bytes still arrive with flags raised.
// - Clock idle level follows clock polarity bit 4 of control one.
// - Bytes go out most significant bit first.
// - Master rate: clock over 4, 16, 64, or half timer 2 output.
// - Sleep freezes a master transfer; it resumes on wake.
// - Slave shifting follows external clock and continues during sleep.
// - Slave byte sets the serial flag; enabled flag wakes the device.
// - Reset disables the port and aborts any transfer.
// - Polarity and edge-select bits map to the four standard modes.
// - With edge-select 1, sample phase bit picks the sampling point in the bit period.
// - Serial interrupt enable is bit 3 of the enable register.
// - With priority scheme off, the peripheral group enable also gates.
// - Control and status reset to zero, priority to ones; buffer kept.
`timescale 1ns/100ps

module spi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,       // System clock.
  input  wire logic             reset,     // Synchronous reset.
  input  wire logic             in_valid,  // Write side offers a word.
  output logic                  in_ready,  // Room for a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word written.
  output logic                  out_valid, // A word is held.
  input  wire logic             out_ready, // Read side takes the word.
  output logic      [WIDTH-1:0] out_data   // Oldest word.
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW + 1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

module spi_port (
  input  wire logic       clk,       // System clock, 125 MHz.
  input  wire logic       reset,     // Synchronous reset, active high.
  input  wire logic [2:0] addr,      // Register offset.
  input  wire logic [7:0] wdata,     // Register write data.
  input  wire logic       wr,        // Register write strobe.
  input  wire logic       rd,        // Register read strobe.
  output logic      [7:0] rdata,     // Read data, cycle after strobe.
  input  wire logic       sleep,     // Device is asleep.
  input  wire logic       tmr2_tick, // Timer 2 output pulse.
  input  wire logic       sck_i,     // Serial clock pin level.
  output logic            sck_o,     // Serial clock driven value.
  output logic            sck_oe,    // Serial clock driven.
  input  wire logic       sdi,       // Serial data in.
  output logic            sdo,       // Serial data out value.
  output logic            sdo_oe,    // Serial data out driven.
  input  wire logic       ss_n,      // Slave select, active low.
  output logic            irq_wake   // Serial interrupt request and wake.
);
  logic [7:0]  pie_r;
  logic [7:0]  pir_r;
  logic [7:0]  ipr_r;
  logic [7:0]  con1_r;
  logic [7:0]  stat_r;
  logic [7:0]  ctl_r;
  logic [7:0]  buf_r;
  logic        bf_r;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic        samp_r;
  logic [3:0]  edge_r;
  logic [5:0]  cnt_r;
  logic        sck_prev_r;
  spi_pkg::xfer_state_t state_r;
  spi_pkg::link_cfg_t cfg;

  logic en;
  logic master;
  logic slave;
  logic ss_ok;
  logic cpha;
  logic [5:0] half;
  logic m_tick;
  logic m_edge;
  logic s_edge;
  logic edge_evt;
  logic done;
  logic busy;
  logic wr_buf;
  logic rd_buf;
  logic launch;
  logic new_bit;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  assign cfg    = {stat_r[spi_pkg::STAT_SMP], stat_r[spi_pkg::STAT_CKE],
                   con1_r[spi_pkg::CON_CKP], con1_r[3:0]};
  assign en     = con1_r[spi_pkg::CON_EN];
  assign master = en & (cfg.mode <= spi_pkg::MODE_TMR2);
  assign slave  = en & ((cfg.mode == spi_pkg::MODE_SLV_SS) |
                        (cfg.mode == spi_pkg::MODE_SLV));
  assign ss_ok  = (cfg.mode == spi_pkg::MODE_SLV) | ~ss_n;
  // Edge-select 1 launches data ahead of the first edge.
  assign cpha   = ~cfg.cke;
  assign wr_buf = wr & (addr == spi_pkg::OFF_BUF);
  assign rd_buf = rd & (addr == spi_pkg::OFF_BUF);
  assign busy   = master ? (state_r != spi_pkg::ST_IDLE) : (edge_r != '0);
  assign launch = master & wr_buf & (state_r == spi_pkg::ST_IDLE);

  always_comb begin
    unique case (cfg.mode)
      spi_pkg::MODE_DIV16: half = spi_pkg::HALF_DIV16;
      spi_pkg::MODE_DIV64: half = spi_pkg::HALF_DIV64;
      default:             half = spi_pkg::HALF_DIV4;
    endcase
  end

  // The baud counter stands still in sleep, freezing the transfer.
  assign m_tick = (cfg.mode == spi_pkg::MODE_TMR2) ? tmr2_tick
                : (cnt_r == half - 6'h01);
  assign m_edge = master & (state_r == spi_pkg::ST_SHIFT) & ~sleep
                & m_tick;
  // Slave edges come from the pin and ignore sleep.
  assign s_edge = slave & ss_ok & (sck_i != sck_prev_r);
  assign edge_evt = m_edge | s_edge;
  assign done     = edge_evt & (edge_r == spi_pkg::LAST_EDGE);

  // Sample phase 1 takes the pin at the shifting edge, the end of the bit with edge-select 1.
  assign new_bit   = (cfg.sample_phase_bit | cpha) ? sdi : samp_r;
  assign shift_nxt = {shift_r[6:0], new_bit};

  always_ff @(posedge clk) begin
    if (reset || !master) begin
      state_r <= spi_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        spi_pkg::ST_IDLE: begin
          if (launch) begin
            state_r <= fifo_in_ready ? spi_pkg::ST_SHIFT
                                     : spi_pkg::ST_WAIT;
          end
        end
        spi_pkg::ST_WAIT: begin
          if (fifo_in_ready) begin
            state_r <= spi_pkg::ST_SHIFT;
          end
        end
        spi_pkg::ST_SHIFT: begin
          if (done) begin
            state_r <= spi_pkg::ST_IDLE;
          end
        end
        default: state_r <= spi_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_r != spi_pkg::ST_SHIFT || m_edge) begin
      cnt_r <= '0;
    end else if (!sleep) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= sck_i;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !en) begin
      edge_r <= '0;
    end else if (slave && !ss_ok) begin
      edge_r <= '0;
    end else if (edge_evt) begin
      edge_r <= edge_r + 4'h1;
    end
  end

  // Send and receive share the same edges of the shift register.
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_r <= '0;
      samp_r  <= 1'b0;
    end else begin
      if (wr_buf && !busy) begin
        shift_r <= wdata;
      end else if (edge_evt && edge_r[0]) begin
        shift_r <= shift_nxt;
      end
      if (edge_evt && (edge_r[0] == cpha)) begin
        samp_r <= sdi;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sdo <= 1'b0;
    end else if (wr_buf && !busy) begin
      sdo <= wdata[7];
    end else if (edge_evt && !cpha && edge_r[0]) begin
      sdo <= shift_r[6];
    end else if (edge_evt && cpha && !edge_r[0]) begin
      sdo <= shift_r[7];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sdo_oe <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      sdo_oe <= ~ctl_r[spi_pkg::CTL_SDO_OFF]
              & (master | (slave & ss_ok));
      sck_oe <= master;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_o <= 1'b0;
    end else if (state_r != spi_pkg::ST_SHIFT) begin
      sck_o <= cfg.clock_polarity_bit;
    end else if (m_edge) begin
      sck_o <= ~sck_o;
    end
  end

  spi_fifo #(
    .WIDTH (spi_pkg::BYTE_W),
    .DEPTH (spi_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (done),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_nxt),
    .out_valid (fifo_out_valid),
    .out_ready (~bf_r),
    .out_data  (fifo_out_data)
  );

  // Buffer has no reset so its contents survive a reset.
  always_ff @(posedge clk) begin
    if (fifo_out_valid && !bf_r) begin
      buf_r <= fifo_out_data;
    end else if (wr_buf && !busy) begin
      buf_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bf_r <= 1'b0;
    end else if (fifo_out_valid && !bf_r) begin
      bf_r <= 1'b1;
    end else if (rd_buf) begin
      bf_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pie_r <= spi_pkg::RST_ZERO;
      ipr_r <= spi_pkg::RST_ONES;
      ctl_r <= spi_pkg::RST_ZERO;
    end else if (wr) begin
      if (addr == spi_pkg::OFF_IRQ_EN) begin
        pie_r <= wdata;
      end
      if (addr == spi_pkg::OFF_IRQ_PRIO) begin
        ipr_r <= wdata;
      end
      if (addr == spi_pkg::OFF_CTL) begin
        ctl_r <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pir_r <= spi_pkg::RST_ZERO;
    end else begin
      if (wr && addr == spi_pkg::OFF_IRQ_FLAGS) begin
        pir_r <= wdata;
      end
      if (done) begin
        pir_r[spi_pkg::IRQ_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      con1_r <= spi_pkg::RST_ZERO;
      stat_r <= spi_pkg::RST_ZERO;
    end else begin
      if (wr && addr == spi_pkg::OFF_CON1) begin
        con1_r <= wdata;
      end
      if (wr && addr == spi_pkg::OFF_STAT) begin
        stat_r <= {wdata[7:6], 6'h00};
      end
      if (wr_buf && busy) begin
        con1_r[spi_pkg::CON_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (done && !fifo_in_ready) begin
        con1_r[spi_pkg::CON_OV] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_wake <= 1'b0;
    end else begin
      irq_wake <= pir_r[spi_pkg::IRQ_BIT] & pie_r[spi_pkg::IRQ_BIT]
                & (ctl_r[spi_pkg::CTL_PRIO] | ctl_r[spi_pkg::CTL_GROUP]);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        spi_pkg::OFF_IRQ_EN:    rdata <= pie_r;
        spi_pkg::OFF_IRQ_FLAGS: rdata <= pir_r;
        spi_pkg::OFF_IRQ_PRIO:  rdata <= ipr_r;
        spi_pkg::OFF_BUF:       rdata <= buf_r;
        spi_pkg::OFF_CON1:      rdata <= con1_r;
        spi_pkg::OFF_STAT:      rdata <= {stat_r[7:1], bf_r};
        spi_pkg::OFF_CTL:       rdata <= ctl_r;
        default:                rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

// ---- verif/spi_port_asserts.sv ----
// Assertions on the serial port pins.
// Assumes a bind to spi_port; sees only its ports.
`timescale 1ns/100ps
module spi_port_asserts (
  input wire logic       clk,     // Clock.
  input wire logic       reset,   // Reset.
  input wire logic [2:0] addr,    // Offset.
  input wire logic [7:0] wdata,   // Write data.
  input wire logic       wr,      // Write strobe.
  input wire logic       sleep,   // Sleep.
  input wire logic       sck_o,   // Serial clock.
  input wire logic       sck_oe,  // Clock driven.
  input wire logic       sdo,     // Data out.
  input wire logic       sdo_oe,  // Data driven.
  input wire logic       irq_wake // Request.
);
  logic       en_r, grp_r, off_r, cpol_r, cke_r, b7_r;
  logic [3:0] mode_r;
  logic [6:0] stab_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      {en_r, grp_r, off_r, cpol_r, cke_r, mode_r} <= '0;
    end else if (wr) begin
      if (addr == spi_pkg::OFF_IRQ_EN) en_r <= wdata[3];
      if (addr == spi_pkg::OFF_CTL) grp_r <= wdata[7] | wdata[6];
      if (addr == spi_pkg::OFF_CTL) off_r <= wdata[0];
      if (addr == spi_pkg::OFF_CON1) {cpol_r, mode_r} <= wdata[4:0];
      if (addr == spi_pkg::OFF_STAT) cke_r <= wdata[6];
    end
  end

  // Counts clocks since the serial clock last moved.
  always_ff @(posedge clk) begin
    if (wr && addr == spi_pkg::OFF_BUF) b7_r <= wdata[7];
    if (reset || $changed(sck_o)) stab_r <= 7'h00;
    else if (stab_r != 7'h7F) stab_r <= stab_r + 7'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_start;
    wr && addr == spi_pkg::OFF_BUF && sck_oe && stab_r > 7'h28;
  endsequence

  AST_RESET_QUIET:
    assert property ($fell(reset) |-> !sck_oe && !sdo_oe && !irq_wake)
    else $error("Pins driven after reset.");
  AST_SLEEP_FREEZE:
    assert property (sleep && sck_oe |=> $stable(sck_o) && $stable(sdo))
    else $error("Pins moved in sleep.");
  AST_IRQ_GATED:
    assert property (irq_wake |-> $past(en_r) && $past(grp_r))
    else $error("Request while masked.");
  AST_SDO_OFF:
    assert property (sdo_oe |-> !$past(off_r))
    else $error("Data out driven while off.");
  AST_IDLE_LEVEL:
    assert property (sck_oe && stab_r == 7'h64 |-> sck_o == cpol_r)
    else $error("Clock idles at wrong level.");
  AST_START_NOW:
    assert property (s_start |-> ##[1:40] $changed(sck_o))
    else $error("Write did not start clock.");
  AST_MSB_FIRST:
    assert property (s_start ##0 cke_r |=> ##[0:1] sdo == b7_r)
    else $error("First bit is not top bit.");
  AST_RATE_DIV16:
    assert property ($changed(sck_o) && sck_oe
      && mode_r == spi_pkg::MODE_DIV16 |=> $stable(sck_o)[*7])
    else $error("Half period too short.");
endmodule

// ---- verif/spi_slave_model.sv ----
// Far-side serial slave answering a master.
// Assumes at least two clocks per serial half period.
`timescale 1ns/100ps
module spi_slave_model (
  input  wire logic       clk,     // Clock.
  input  wire logic       mrst,    // Frame restart.
  input  wire logic       sck,     // Serial clock.
  input  wire logic       sdo,     // Master data.
  input  wire logic       cpol,    // Idle level.
  input  wire logic       cke,     // Edge select.
  input  wire logic [7:0] tx_byte, // Byte to send.
  output logic            sdi,     // Slave data.
  output logic      [7:0] rx_byte, // Byte received.
  output logic            done     // Byte complete.
);
  logic       sck_q;
  logic [3:0] cnt;
  logic [7:0] tx_r, rx_r;

  assign sdi = tx_r[7];

  // Data moves on the edge opposite to the one that samples it.
  always @(posedge clk) begin
    sck_q <= sck;
    if (mrst) begin
      cnt  <= 4'h0;
      done <= 1'b0;
      tx_r <= tx_byte;
    end else if (sck != sck_q) begin
      cnt <= cnt + 4'h1;
      if ((sck != cpol) == cke)
        rx_r <= {rx_r[6:0], sdo};
      else if (cke || cnt != 4'h0)
        tx_r <= {tx_r[6:0], !tx_r[7]};
      if (cnt == 4'hF) begin
        rx_byte <= cke ? rx_r : {rx_r[6:0], sdo};
        done    <= 1'b1;
      end
    end
  end
endmodule

// ---- verif/spi_port_tb.sv ----
// Self-checking bench of the serial port as master and as slave.
// Assumes the checker and slave model are compiled first.
`timescale 1ns/100ps
module spi_port_tb;
  logic       clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic       sleep = 1'b0, tick = 1'b0, mrst = 1'b1;
  logic       cpol = 1'b0, cke = 1'b1;
  logic       slv = 1'b0, ssck = 1'b0, ssdi = 1'b0, ssn = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, txb = 8'h00;
  logic [7:0] rdata, mrx, got, d;
  logic       sck_o, sck_oe, sdo, sdo_oe, irq_wake, sdi, mdone;
  int         mismatches = 0, checks_done = 0, cyc = 0;
  int         seed = 32'hf34c;
  logic [7:0] exp_q[$];

  always #4 clk = ~clk;

  spi_port DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep), .tmr2_tick(tick),
    .sck_i(slv ? ssck : sck_o), .sck_o(sck_o), .sck_oe(sck_oe),
    .sdi(slv ? ssdi : sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ss_n(ssn),
    .irq_wake(irq_wake));

  // A pull-up holds the data line high while the port releases it.
  spi_slave_model peer (.clk(clk), .mrst(mrst), .sck(sck_o),
    .sdo(sdo_oe ? sdo : 1'b1),
    .cpol(cpol), .cke(cke), .tx_byte(txb), .sdi(sdi), .rx_byte(mrx),
    .done(mdone));

  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc  <= cyc + 1;
    tick <= (cyc % 4 == 0);
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    wreg(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rreg(3'(a), got);
      if (a != 3) chk("reset value", got, a == 2 ? 8'hFF : 8'h00);
    end
    wreg(spi_pkg::OFF_IRQ_EN, 8'h08);
    // One pass per standard mode and master rate.
    for (int i = 0; i < 4; i++) begin
      cpol <= i[1];
      cke  <= !i[0];
      txb  <= 8'($random(seed));
      wreg(spi_pkg::OFF_STAT, {1'($random(seed)), !i[0], 6'h00});
      d = i == 0 ? 8'h40 : i == 1 ? 8'h80 : i == 2 ? 8'h00 : 8'hC1;
      wreg(spi_pkg::OFF_CTL, d);
      wreg(spi_pkg::OFF_CON1, {3'b001, i[1], 2'b00, i[1:0]});
      mrst <= 1'b1;
      repeat (3) @(posedge clk);
      mrst <= 1'b0;
      exp_q.push_back(txb);
      d = 8'($random(seed));
      wreg(spi_pkg::OFF_BUF, d);
      if (i == 1) wreg(spi_pkg::OFF_BUF, ~d);
      if (i == 2) begin
        repeat (40) @(posedge clk);
        sleep <= 1'b1;
        repeat (50) @(posedge clk);
        sleep <= 1'b0;
      end
      for (int n = 0; n < 3000 && !mdone; n++) @(posedge clk);
      repeat (4) @(posedge clk);
      rreg(spi_pkg::OFF_BUF, got);
      chk("received", got, exp_q.pop_front());
      chk("sent", mrx, i == 3 ? 8'hFF : d);
      chk("request", 8'(irq_wake), 8'(i != 2));
      chk("out enable", 8'(sdo_oe), 8'(i != 3));
      rreg(spi_pkg::OFF_IRQ_FLAGS, got);
      chk("flag", got, 8'h08);
      rreg(spi_pkg::OFF_CON1, got);
      chk("collision", got, {i == 1, 2'b01, i[1], 2'b00, i[1:0]});
      wreg(spi_pkg::OFF_IRQ_FLAGS, 8'h00);
    end
    repeat (120) @(posedge clk);
    wreg(spi_pkg::OFF_BUF, 8'h5A);
    repeat (10) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk("clock driven", 8'(sck_oe), 8'h00);
    rreg(spi_pkg::OFF_CON1, got);
    chk("control", got, 8'h00);
    rreg(spi_pkg::OFF_BUF, got);
    chk("buffer kept", got, 8'h5A);
    // Selected slave frame while asleep; the bench drives the clock.
    wreg(spi_pkg::OFF_IRQ_EN, 8'h08);
    slv <= 1'b1;
    ssn <= 1'b0;
    wreg(spi_pkg::OFF_CTL, 8'h40);
    wreg(spi_pkg::OFF_STAT, 8'h40);
    wreg(spi_pkg::OFF_CON1, 8'h24);
    sleep <= 1'b1;
    d = 8'($random(seed));
    for (int b = 7; b >= 0; b--) begin
      ssdi <= d[b];
      repeat (2) @(posedge clk);
      ssck <= 1'b1;
      repeat (2) @(posedge clk);
      ssck <= 1'b0;
    end
    repeat (6) @(posedge clk);
    #1 chk("slave request", 8'(irq_wake), 8'h01);
    rreg(spi_pkg::OFF_BUF, got);
    chk("slave received", got, d);
    sleep <= 1'b0;
    print_verdict();
  end
endmodule

bind spi_port spi_port_asserts chk_i (.clk(clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .sleep(sleep), .sck_o(sck_o),
  .sck_oe(sck_oe), .sdo(sdo), .sdo_oe(sdo_oe), .irq_wake(irq_wake));
